// ===== nvm_seq_pkg.sv
// Constants and types shared by the nonvolatile memory erase/write sequencer
package nvm_seq_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_WPROT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_WR = 0;
  localparam int CTRL_WEN = 1;
  localparam int CTRL_ERASE = 2;
  localparam int CTRL_REGION = 3;
  localparam int CTRL_DONE = 4;
  localparam int CTRL_IRQEN = 5;
  // ----------------------------------------------------------------
  // Unlock keys, address map and array geometry
  // ----------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam logic [14:0] EE_FIRST = 15'h7000;
  localparam logic [14:0] EE_LAST = 15'h70FF;
  localparam logic [14:0] UID_LAST = 15'h0003;
  localparam int ROW_LSB = 5; // 32 words per row
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  localparam logic [1:0] KEY_NONE = 2'h0;
  localparam logic [1:0] KEY_GOT_FIRST = 2'h1;
  localparam logic [1:0] KEY_ARMED = 2'h2;
  // ----------------------------------------------------------------
  // Operation lengths in clock cycles
  // ----------------------------------------------------------------
  localparam logic [15:0] EE_ERASE_CYCLES = 16'h0040;
  localparam logic [15:0] EE_PROG_CYCLES = 16'h0040;
  localparam logic [15:0] ROW_ERASE_CYCLES = 16'h0080;
  // ----------------------------------------------------------------
  // State and command types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EE_ERASE, ST_EE_PROG,
                            ST_ROW_ERASE} seq_state_t;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_ERASE_WORD = 2'h1;
  localparam logic [1:0] CMD_PROG_WORD = 2'h2;
  localparam logic [1:0] CMD_ERASE_ROW = 2'h3;
endpackage : nvm_seq_pkg

// ===== nvm_erase_write_sequencer.sv
// Erase/write sequencer for on-chip nonvolatile memory, AHB-Lite slave
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module nvm_erase_write_sequencer
  import nvm_seq_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Protection pin
  input wire logic code_protect_in,
  // Array command port
  output logic [1:0] mem_cmd_out,
  output logic mem_region_out,
  output logic [14:0] mem_addr_out,
  output logic [13:0] mem_wdata_out,
  // CPU side
  output logic cpu_stall_out,
  output logic nvm_irq_out
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic wr_q, wr_d, wen_q, wen_d, erase_q, erase_d;
  logic region_q, region_d, done_q, done_d, irqen_q, irqen_d;
  logic reject_q, reject_d;
  logic [1:0] key_q, key_d;
  logic [14:0] addr_q, addr_d, wprot_q, wprot_d;
  logic [13:0] data_q, data_d;
  logic wpend_q, wpend_d, rpend_q, rpend_d;
  logic [7:0] ofs_q, ofs_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic [1:0] cmd_q, cmd_d;
  logic mregion_q, mregion_d, stall_q, stall_d, irq_q, irq_d;
  logic [14:0] maddr_q, maddr_d;
  logic [13:0] mdata_q, mdata_d;
  logic cp_meta_q, cp_q;
  logic bus_take, wr_ctrl, wr_key, start_req, ee_ok, row_ok, go_ee, go_row;
  logic phase_end;

  // ----------------------------------------------------------------
  // Protection pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cp_meta_q <= 1'b0;
      cp_q <= 1'b0;
    end else begin
      cp_meta_q <= code_protect_in;
      cp_q <= cp_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Bus phase tracking
  // ----------------------------------------------------------------
  // Transfer taken in address phase; reads get one wait state
  assign bus_take = hsel_in && htrans_in[1] && hready_in;
  assign wr_ctrl = wpend_q && (ofs_q == OFS_CTRL);
  assign wr_key = wpend_q && (ofs_q == OFS_KEY);
  assign start_req = wr_ctrl && hwdata_in[CTRL_WR] && (state_q == ST_IDLE);

  always_comb begin
    wpend_d = bus_take && hwrite_in;
    rpend_d = bus_take && !hwrite_in;
    ofs_d = bus_take ? haddr_in[7:0] : ofs_q;
    ready_d = !rpend_d;
    rdata_d = rdata_q;
    if (rpend_q) begin
      unique case (ofs_q)
        OFS_CTRL: rdata_d = {26'h0, irqen_q, done_q, region_q, erase_q,
                             wen_q, wr_q};
        OFS_ADDR: rdata_d = {17'h0, addr_q};
        OFS_DATA: rdata_d = {18'h0, data_q};
        OFS_WPROT: rdata_d = {17'h0, wprot_q};
        OFS_STAT: rdata_d = {27'h0, reject_q, key_q, stall_q,
                             state_q != ST_IDLE};
        default: rdata_d = 32'h0000_0000; // Key and unmapped read zero
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wpend_q <= 1'b0;
      rpend_q <= 1'b0;
      ofs_q <= 8'h00;
      ready_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wpend_q <= wpend_d;
      rpend_q <= rpend_d;
      ofs_q <= ofs_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Unlock key tracking
  // ----------------------------------------------------------------
  // Any other register write breaks the sequence
  always_comb begin
    key_d = key_q;
    if (wr_key) begin
      if (hwdata_in[7:0] == KEY_FIRST) begin
        key_d = KEY_GOT_FIRST;
      end else if (hwdata_in[7:0] == KEY_SECOND && key_q == KEY_GOT_FIRST)
      begin
        key_d = KEY_ARMED;
      end else begin
        key_d = KEY_NONE;
      end
    end else if (wpend_q) begin
      key_d = KEY_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Start qualification
  // ----------------------------------------------------------------
  // EEPROM word write: region set, no erase, address inside EEPROM
  assign ee_ok = region_q && !erase_q && addr_q >= EE_FIRST
                 && addr_q <= EE_LAST;
  // Row erase: flash above the protected boundary, or user IDs
  assign row_ok = erase_q && (region_q ? (addr_q <= UID_LAST)
                 : (addr_q >= wprot_q));
  assign go_ee = start_req && key_q == KEY_ARMED && wen_q && !cp_q
                 && ee_ok;
  assign go_row = start_req && key_q == KEY_ARMED && wen_q && !cp_q
                  && row_ok;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_comb begin
    wen_d = wen_q;
    erase_d = erase_q;
    region_d = region_q;
    irqen_d = irqen_q;
    addr_d = addr_q;
    data_d = data_q;
    wprot_d = wprot_q;
    wr_d = wr_q;
    done_d = done_q;
    reject_d = reject_q;
    if (wr_ctrl) begin
      wen_d = hwdata_in[CTRL_WEN];
      irqen_d = hwdata_in[CTRL_IRQEN];
      if (hwdata_in[CTRL_DONE]) begin
        done_d = 1'b0; // Write one to clear
      end
      if (state_q == ST_IDLE) begin
        erase_d = hwdata_in[CTRL_ERASE];
        region_d = hwdata_in[CTRL_REGION];
      end
    end
    // Operands stay frozen while an operation runs
    if (wpend_q && state_q == ST_IDLE) begin
      if (ofs_q == OFS_ADDR) begin
        addr_d = hwdata_in[14:0];
      end
      if (ofs_q == OFS_DATA) begin
        data_d = hwdata_in[13:0];
      end
      if (ofs_q == OFS_WPROT) begin
        wprot_d = hwdata_in[14:0];
      end
    end
    // Start bit only set by a qualified start; refused starts flagged
    if (go_ee || go_row) begin
      wr_d = 1'b1;
      reject_d = 1'b0;
    end else if (start_req) begin
      reject_d = 1'b1;
    end
    // Completion clears the start bit and sets the sticky flag
    if (phase_end && (state_q == ST_EE_PROG || state_q == ST_ROW_ERASE))
    begin
      wr_d = 1'b0;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wen_q <= 1'b0;
      erase_q <= 1'b0;
      region_q <= 1'b0;
      irqen_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      wprot_q <= '0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      reject_q <= 1'b0;
      key_q <= KEY_NONE;
    end else begin
      wen_q <= wen_d;
      erase_q <= erase_d;
      region_q <= region_d;
      irqen_q <= irqen_d;
      addr_q <= addr_d;
      data_q <= data_d;
      wprot_q <= wprot_d;
      wr_q <= wr_d;
      done_q <= done_d;
      reject_q <= reject_d;
      key_q <= key_d;
    end
  end

  // ----------------------------------------------------------------
  // Operation sequencer and array command
  // ----------------------------------------------------------------
  assign phase_end = (cnt_q == 16'h0000);

  always_comb begin
    state_d = state_q;
    cnt_d = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (go_ee) begin
          state_d = ST_EE_ERASE;
          cnt_d = EE_ERASE_CYCLES - 16'h0001;
        end else if (go_row) begin
          state_d = ST_ROW_ERASE;
          cnt_d = ROW_ERASE_CYCLES - 16'h0001;
        end
      end
      ST_EE_ERASE: begin
        if (phase_end) begin
          state_d = ST_EE_PROG;
          cnt_d = EE_PROG_CYCLES - 16'h0001;
        end
      end
      ST_EE_PROG: begin
        if (phase_end) begin
          state_d = ST_IDLE;
        end
      end
      ST_ROW_ERASE: begin
        if (phase_end) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    // Array sees erase-word, program-word or erase-row as a level
    cmd_d = CMD_NONE;
    mdata_d = BLANK_WORD;
    maddr_d = addr_q;
    mregion_d = region_q;
    unique case (state_d)
      ST_IDLE: cmd_d = CMD_NONE;
      ST_EE_ERASE: cmd_d = CMD_ERASE_WORD;
      ST_EE_PROG: begin
        cmd_d = CMD_PROG_WORD;
        mdata_d = data_q;
      end
      ST_ROW_ERASE: begin
        cmd_d = CMD_ERASE_ROW;
        maddr_d = {addr_q[14:ROW_LSB], {ROW_LSB{1'b0}}};
      end
    endcase
    stall_d = (state_d == ST_ROW_ERASE);
    irq_d = done_d && irqen_d;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      cmd_q <= CMD_NONE;
      mregion_q <= 1'b0;
      maddr_q <= '0;
      mdata_q <= BLANK_WORD;
      stall_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cmd_q <= cmd_d;
      mregion_q <= mregion_d;
      maddr_q <= maddr_d;
      mdata_q <= mdata_d;
      stall_q <= stall_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign hrdata_out = rdata_q;
  assign hreadyout_out = ready_q;
  assign hresp_out = 1'b0;
  assign mem_cmd_out = cmd_q;
  assign mem_region_out = mregion_q;
  assign mem_addr_out = maddr_q;
  assign mem_wdata_out = mdata_q;
  assign cpu_stall_out = stall_q;
  assign nvm_irq_out = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_start_after_keys:
    assert property ($rose(wr_q) |-> $past(key_q) == KEY_ARMED)
    else $error("operation started without both keys");
  a_first_key_restart:
    assert property (wr_key && hwdata_in[7:0] == KEY_FIRST
                     |=> key_q == KEY_GOT_FIRST)
    else $error("first key did not restart tracking");
  a_ee_erase_first:
    assert property (state_q == ST_EE_ERASE && phase_end
                     |=> state_q == ST_EE_PROG && mem_cmd_out == CMD_PROG_WORD)
    else $error("word erase not followed by program");
  a_ee_no_stall:
    assert property (state_q == ST_EE_ERASE || state_q == ST_EE_PROG
                     |-> !cpu_stall_out)
    else $error("cpu stalled during eeprom write");
  a_done_on_end:
    assert property (state_q == ST_EE_PROG && phase_end
                     |=> done_q && !wr_q && state_q == ST_IDLE)
    else $error("eeprom completion not reported");
  a_start_held:
    assert property (state_q != ST_IDLE |-> wr_q)
    else $error("start bit dropped while busy");
  a_protect_blocks:
    assert property (state_q == ST_IDLE && cp_q |=> state_q == ST_IDLE)
    else $error("operation started under code protection");
  a_row_aligned:
    assert property (mem_cmd_out == CMD_ERASE_ROW
                     |-> mem_addr_out[ROW_LSB-1:0] == '0)
    else $error("row erase address not row aligned");
  a_row_stalls:
    assert property (go_row |=> cpu_stall_out [*2])
    else $error("row erase did not stall cpu");
  a_wen_kept:
    assert property (state_q != ST_IDLE && !wr_ctrl |=> $stable(wen_q))
    else $error("write enable changed by operation");

  c_ee_done: cover property (state_q == ST_EE_PROG && phase_end);
  c_row_done: cover property (state_q == ST_ROW_ERASE && phase_end);
  c_refused: cover property (start_req && !go_ee && !go_row);
endmodule : nvm_erase_write_sequencer
`default_nettype wire

// ===== test_nvm_erase_write_sequencer.sv
// Self-checking testbench for the nonvolatile memory erase/write sequencer
`timescale 1ns/1ps
`default_nettype none
module test_nvm_erase_write_sequencer
  import nvm_seq_pkg::*;
;
  // ----------------------------------------------------------------
  // Clock, bus and observation signals
  // ----------------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic cp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, stall, irq, mreg;
  wire logic [1:0] mcmd;
  wire logic [14:0] maddr;
  wire logic [13:0] mwd;
  int errors = 0;
  int num_checks = 0;

  // Free-running 50 MHz clock
  always #10 mclk_in = ~mclk_in;

  nvm_erase_write_sequencer i_dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .code_protect_in(cp), .mem_cmd_out(mcmd), .mem_region_out(mreg),
    .mem_addr_out(maddr), .mem_wdata_out(mwd), .cpu_stall_out(stall),
    .nvm_irq_out(irq));

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One single AHB-Lite transfer; address held until hready is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge mclk_in);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge mclk_in);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      errors++;
      print_verdict();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rdchk

  // Control setup, both keys, then the start bit as the next writes
  task automatic start(input logic [31:0] ctrl);
    wr(OFS_CTRL, ctrl);
    wr(OFS_KEY, {24'h000000, KEY_FIRST});
    wr(OFS_KEY, {24'h000000, KEY_SECOND});
    wr(OFS_CTRL, ctrl | 32'h1);
  endtask : start

  task automatic wait_cmd(input logic [1:0] c, input int lim);
    int n;
    n = 0;
    while (mcmd !== c && n < lim) begin
      @(posedge mclk_in);
      n++;
    end
    check("mem_cmd", {30'h0, mcmd}, {30'h0, c});
  endtask : wait_cmd

  // Poll the start bit until the operation reports its end
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_CTRL, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 100);
    if (n >= 100) begin
      errors++;
      print_verdict();
    end
  endtask : wait_done

  // A start that must not begin any operation
  task automatic refuse(input logic [31:0] ctrl);
    start(ctrl);
    rdchk("ctrl refused", OFS_CTRL, ctrl & 32'hFFFFFFEE);
    bus(1'b0, OFS_STAT, 32'h0);
    check("refused flag", {31'h0, rd[4]}, 32'h1);
    check("no command", {30'h0, mcmd}, 32'h0);
  endtask : refuse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in);
    rdchk("ctrl reset", OFS_CTRL, 32'h0);
    rdchk("key read", OFS_KEY, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
    check("wdata reset", {18'h0, mwd}, {18'h0, BLANK_WORD});
    check("hresp okay", {31'h0, hresp}, 32'h0);
    // Start bit without keys is dropped
    wr(OFS_CTRL, 32'h2A);
    wr(OFS_CTRL, 32'h2B);
    rdchk("ctrl no keys", OFS_CTRL, 32'h2A);
    // Key stage tracking and interrupted sequences
    wr(OFS_KEY, 32'h55);
    rdchk("stage first", OFS_STAT, 32'h14);
    wr(OFS_KEY, 32'h12);
    rdchk("stage wrong", OFS_STAT, 32'h10);
    wr(OFS_KEY, 32'h55);
    wr(OFS_KEY, 32'h55);
    wr(OFS_KEY, 32'hAA);
    rdchk("stage armed", OFS_STAT, 32'h18);
    wr(OFS_ADDR, 32'h7010);
    wr(OFS_CTRL, 32'h2B);
    rdchk("ctrl broken seq", OFS_CTRL, 32'h2A);
    // EEPROM word write with interrupt enabled
    wr(OFS_DATA, 32'h1234);
    start(32'h2A);
    wait_cmd(CMD_ERASE_WORD, 4);
    check("ee addr", {17'h0, maddr}, 32'h7010);
    check("ee blank", {18'h0, mwd}, {18'h0, BLANK_WORD});
    check("ee no stall", {31'h0, stall}, 32'h0);
    check("ee region", {31'h0, mreg}, 32'h1);
    wr(OFS_CTRL, 32'h2A);
    rdchk("ctrl busy", OFS_CTRL, 32'h2B);
    rdchk("stat busy", OFS_STAT, 32'h1);
    wait_cmd(CMD_PROG_WORD, 80);
    check("ee data", {18'h0, mwd}, 32'h1234);
    wait_done();
    check("ctrl ee done", rd, 32'h3A);
    check("irq on", {31'h0, irq}, 32'h1);
    wr(OFS_CTRL, 32'h1A);
    repeat (2) @(posedge mclk_in);
    check("irq off", {31'h0, irq}, 32'h0);
    // Program flash row erase, interrupt disabled
    wr(OFS_ADDR, 32'h0133);
    start(32'h06);
    wait_cmd(CMD_ERASE_ROW, 4);
    check("row addr", {17'h0, maddr}, 32'h0120);
    check("row region", {31'h0, mreg}, 32'h0);
    check("row stall", {31'h0, stall}, 32'h1);
    wait_done();
    check("ctrl row done", rd, 32'h16);
    check("irq masked", {31'h0, irq}, 32'h0);
    // User ID row erase
    wr(OFS_ADDR, 32'h0002);
    start(32'h1E);
    wait_cmd(CMD_ERASE_ROW, 4);
    check("uid region", {31'h0, mreg}, 32'h1);
    wait_done();
    check("ctrl uid done", rd, 32'h1E);
    // Refused starts
    wr(OFS_ADDR, 32'h0005);
    refuse(32'h1E);
    wr(OFS_WPROT, 32'h0200);
    wr(OFS_ADDR, 32'h0100);
    refuse(32'h06);
    refuse(32'h02);
    wr(OFS_ADDR, 32'h7100);
    refuse(32'h0A);
    wr(OFS_ADDR, 32'h70FF);
    refuse(32'h08);
    cp <= 1'b1;
    repeat (3) @(posedge mclk_in);
    refuse(32'h0A);
    cp <= 1'b0;
    repeat (3) @(posedge mclk_in);
    start(32'h0A);
    wait_cmd(CMD_ERASE_WORD, 4);
    wait_done();
    check("ctrl final", rd, 32'h1A);
    print_verdict();
  end

  // Watchdog against a hung run
  initial begin
    repeat (50000) @(posedge mclk_in);
    errors++;
    print_verdict();
  end
endmodule : test_nvm_erase_write_sequencer
`default_nettype wire
